// ===== core/cwf_can_wake_failsafe_ctrl.sv
// CAN transceiver wake-up detector and fail-safe control with a Wishbone register port
`timescale 1ns/1ps
`default_nettype none

module cwf_can_wake_failsafe_ctrl
	import cwf_pkg::*;
#(
	parameter int unsigned K_WAKE_DOM = C_WAKE_DOM,
	parameter int unsigned K_WAKE_REC = C_WAKE_REC,
	parameter int unsigned K_WAKE_TO  = C_WAKE_TO,
	parameter int unsigned K_STARTUP  = C_STARTUP,
	parameter int unsigned K_LPF      = C_LPF,
	parameter int unsigned K_DOM_TO   = C_DOM_TO,
	parameter int unsigned K_UV_DET   = C_UV_DET,
	parameter int unsigned K_SWOFF    = C_SWOFF,
	parameter int unsigned K_STB_FLT  = C_STB_FLT
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// host side pins
	input  wire logic        txd_i,
	input  wire logic        txd_float_i,
	input  wire logic        stb_sel_i,
	input  wire logic        stb_float_i,
	output var  logic        rxd_o,
	// bus side
	input  wire logic        bus_rx_i,
	output var  logic        bus_tx_o,
	output var  logic        tx_drv_en_o,
	// comparator flags, synchronous
	input  wire logic        vcc_uv_i,
	input  wire logic        swoff_uv_i,
	input  wire logic        ot_sd_i,
	input  wire logic        ot_rel_i,
	// status
	output var  logic [1:0]  mode_o,
	output var  logic        irq_o,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output var  logic [31:0] wb_dat_o,
	output var  logic        wb_ack_o
);

	// timing counts at counter width
	localparam logic [CW-1:0] KD  = CW'(K_WAKE_DOM);
	localparam logic [CW-1:0] KR  = CW'(K_WAKE_REC);
	localparam logic [CW-1:0] KW  = CW'(K_WAKE_TO);
	localparam logic [CW-1:0] KS  = CW'(K_STARTUP);
	localparam logic [CW-1:0] KL  = CW'(K_LPF);
	localparam logic [CW-1:0] KT  = CW'(K_DOM_TO);
	localparam logic [CW-1:0] KU  = CW'(K_UV_DET);
	localparam logic [CW-1:0] KO  = CW'(K_SWOFF);
	localparam logic [CW-1:0] KF  = CW'(K_STB_FLT);
	localparam logic [CW-1:0] ONE = CW'(1);

	cwf_state_t st_q;  // registered state
	cwf_state_t st_d;  // next state

	logic [NPIN-1:0] raw;     // raw pin vector
	logic            txd;     // effective transmit level
	logic            stb;     // effective select level
	logic            uv_f;    // standby undervoltage detected
	logic            sw_f;    // switch-off undervoltage detected
	logic            txto;    // dominant timeout expired
	logic            armed;   // wake detector may run
	logic            hit;     // new bus request
	logic [4:0]      ev;      // event pulses
	logic [4:0]      w1c;     // status bits to clear

	// saturating increment
	function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] c);
		return (&c) ? c : c + ONE;
	endfunction

	// register address match, upper bits must be zero
	function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
		return a[7:2] == off[7:2];
	endfunction

	// gather pins into the synchroniser vector
	always_comb begin
		raw         = '0;
		raw[P_TXD]  = txd_i;
		raw[P_STB]  = stb_sel_i;
		raw[P_BUS]  = bus_rx_i;
		raw[P_TXF]  = txd_float_i;
		raw[P_STBF] = stb_float_i;
	end

	// next state
	always_comb begin
		st_d    = st_q;
		// three-stage synchroniser, accept when stages two and three agree
		st_d.s1 = raw;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		for (int i = 0; i < NPIN; i++) begin
			if (st_q.s2[i] == st_q.s3[i]) begin
				st_d.pin[i] = st_q.s3[i];
			end
		end
		// a floating input reads high
		txd = st_q.pin[P_TXD] | st_q.pin[P_TXF];
		stb = st_q.pin[P_STB] | st_q.pin[P_STBF];

		// select filter: accept only after a steady new level
		if (stb == st_q.stb_f) begin
			st_d.stb_cnt = '0;
		end else if (st_q.stb_cnt >= KF - ONE) begin
			st_d.stb_f   = stb;
			st_d.stb_cnt = '0;
		end else begin
			st_d.stb_cnt = st_q.stb_cnt + ONE;
		end

		// undervoltage hold counters
		st_d.uv_cnt = vcc_uv_i ? sat_inc(st_q.uv_cnt) : '0;
		st_d.sw_cnt = swoff_uv_i ? sat_inc(st_q.sw_cnt) : '0;
		uv_f        = st_q.uv_cnt >= KU;
		sw_f        = st_q.sw_cnt >= KO;

		// mode selection, supply faults first
		if (sw_f) begin
			st_d.mode = M_OFF;
		end else if (uv_f) begin
			st_d.mode = M_STBY;
		end else begin
			st_d.mode = st_q.stb_f ? M_STBY : M_NORM;
		end

		// dominant timeout timer
		st_d.txd_cnt = txd ? '0 : sat_inc(st_q.txd_cnt);
		txto         = st_q.txd_cnt > KT;

		// overtemperature lock and gated release
		if (ot_sd_i) begin
			st_d.ot_lock = 1'b1;
		end else if (ot_rel_i && txd && st_q.mode == M_NORM) begin
			st_d.ot_lock = 1'b0;
		end

		// low-power bus filter and run length of the filtered level
		st_d.run_cnt = sat_inc(st_q.run_cnt);
		if (st_q.pin[P_BUS] == st_q.bus_lp) begin
			st_d.lp_cnt = '0;
		end else if (st_q.lp_cnt >= KL - ONE) begin
			st_d.bus_lp  = st_q.pin[P_BUS];
			st_d.lp_cnt  = '0;
			st_d.run_cnt = '0;
		end else begin
			st_d.lp_cnt = st_q.lp_cnt + ONE;
		end

		// wake pattern detector
		armed        = st_q.mode == M_STBY && st_q.ctrl[CTRL_WAKE_EN] && !st_q.wake;
		st_d.win_cnt = (st_q.wst == W_IDLE) ? KD : sat_inc(st_q.win_cnt);
		ev           = '0;
		if (!armed) begin
			st_d.wst = W_IDLE;
		end else if (st_q.wst != W_IDLE && st_q.win_cnt >= KW) begin
			st_d.wst = W_IDLE;
		end else begin
			case (st_q.wst)
				// first dominant phase long enough
				W_IDLE: begin
					if (!st_q.bus_lp && st_q.run_cnt >= KD) begin
						st_d.wst = W_REC;
					end
				end
				// recessive phase long enough, short dominants ignored
				W_REC: begin
					if (st_q.bus_lp && st_q.run_cnt >= KR) begin
						st_d.wst = W_DOM2;
					end
				end
				// second dominant phase completes the pattern
				W_DOM2: begin
					if (!st_q.bus_lp && st_q.run_cnt >= KD) begin
						st_d.wst      = W_IDLE;
						st_d.wake     = 1'b1;
						ev[EV_WAKE]   = 1'b1;
					end
				end
				default: begin
					st_d.wst = W_IDLE;
				end
			endcase
		end
		// wake flag ends when Standby is left
		if (st_q.mode != M_STBY) begin
			st_d.wake = 1'b0;
		end
		st_d.su_cnt = st_q.wake ? sat_inc(st_q.su_cnt) : '0;

		// receive output
		if (st_q.mode == M_NORM) begin
			st_d.rxd = st_q.pin[P_BUS];
		end else if (st_q.mode == M_STBY && st_q.wake && st_q.su_cnt >= KS) begin
			st_d.rxd = st_q.bus_lp;
		end else begin
			st_d.rxd = 1'b1;
		end

		// transmitter enable and drive
		st_d.drv_en = st_q.mode == M_NORM && !txto && !st_q.ot_lock && !ot_sd_i
			&& !st_q.ctrl[CTRL_TX_OFF];
		st_d.tx     = st_d.drv_en && !txd;

		// rising edges of fault levels become events
		ev[EV_TXTO]  = txto & ~st_q.evp[0];
		ev[EV_OT]    = st_q.ot_lock & ~st_q.evp[1];
		ev[EV_UV]    = uv_f & ~st_q.evp[2];
		ev[EV_SWOFF] = sw_f & ~st_q.evp[3];
		st_d.evp     = {sw_f, uv_f, st_q.ot_lock, txto};

		// bus slave: one wait state, ack for one cycle
		hit         = wb_cyc_i && wb_stb_i && !st_q.ack;
		st_d.ack    = hit;
		st_d.dat    = '0;
		w1c         = '0;
		// a write lands at the edge where the master samples ack, while it still holds the request
		if (wb_cyc_i && wb_stb_i && st_q.ack && wb_we_i && wb_sel_i[0]) begin
			if (is_reg(wb_adr_i, REG_STATUS)) begin
				w1c = wb_dat_i[4:0];
			end else if (is_reg(wb_adr_i, REG_MASK)) begin
				st_d.mask = wb_dat_i[4:0];
			end else if (is_reg(wb_adr_i, REG_CTRL)) begin
				st_d.ctrl = wb_dat_i[1:0];
			end
		end else if (hit && !wb_we_i) begin
			if (is_reg(wb_adr_i, REG_STATUS)) begin
				st_d.dat[4:0] = st_q.sts;
			end else if (is_reg(wb_adr_i, REG_MASK)) begin
				st_d.dat[4:0] = st_q.mask;
			end else if (is_reg(wb_adr_i, REG_STATE)) begin
				st_d.dat[9:0] = {st_q.wst, st_q.stb_f, sw_f, uv_f, st_q.ot_lock,
					txto, st_q.wake, st_q.mode};
			end else if (is_reg(wb_adr_i, REG_CTRL)) begin
				st_d.dat[1:0] = st_q.ctrl;
			end
		end
		// a new event beats a clear in the same cycle
		st_d.sts = (st_q.sts & ~w1c) | ev;
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q        <= '0;
			st_q.s1     <= '1;
			st_q.s2     <= '1;
			st_q.s3     <= '1;
			st_q.pin    <= '1;
			st_q.stb_f  <= 1'b1;
			st_q.bus_lp <= 1'b1;
			st_q.rxd    <= 1'b1;
			st_q.mask   <= MASK_RST;
			st_q.ctrl   <= CTRL_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs
	assign rxd_o       = st_q.rxd;
	assign bus_tx_o    = st_q.tx;
	assign tx_drv_en_o = st_q.drv_en;
	assign mode_o      = st_q.mode;
	assign irq_o       = |(st_q.sts & st_q.mask);
	assign wb_dat_o    = st_q.dat;
	assign wb_ack_o    = st_q.ack;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// receive output stays high in Standby until a wake event
	rxd_held_a: assert property ((st_q.mode == M_STBY && !st_q.wake) |=> rxd_o)
		else $error("receive output not high before wake");

	// a dominant timeout turns the transmitter off on the next edge
	txto_off_a: assert property ((st_q.txd_cnt > KT) |=> !tx_drv_en_o)
		else $error("transmitter still on after dominant timeout");

	// a high transmit level empties the timeout timer
	txd_clr_a: assert property (txd |=> st_q.txd_cnt == '0)
		else $error("timeout timer not cleared by high transmit");

	// a low transmit level starts the timeout timer
	txd_start_a: assert property (!txd |=> st_q.txd_cnt != '0)
		else $error("timeout timer did not start on low transmit");

	// a hot junction shuts the drivers on the next edge
	ot_off_a: assert property (ot_sd_i |=> !tx_drv_en_o)
		else $error("drivers on during overtemperature");

	// the lock holds while the junction is not yet cool
	ot_hold_a: assert property ((st_q.ot_lock && !ot_rel_i) |=> st_q.ot_lock)
		else $error("overtemperature lock released while hot");

	// the lock lifts only when cool, transmit high and Normal selected
	ot_free_a: assert property ($fell(st_q.ot_lock) |->
		($past(ot_rel_i) && $past(txd) && $past(st_q.mode) == M_NORM))
		else $error("overtemperature lock released without its conditions");

	// bus phases shorter than the filter never move the filtered level
	lpf_hold_a: assert property ((st_q.lp_cnt < KL - ONE) |=> $stable(st_q.bus_lp))
		else $error("filtered bus moved before filter time");

	// select changes shorter than the filter time are not accepted
	stb_hold_a: assert property ((st_q.stb_cnt < KF - ONE) |=> $stable(st_q.stb_f))
		else $error("select accepted before filter time");

	// the wake flag rises only from a long enough second dominant phase
	wake_pat_a: assert property ($rose(st_q.wake) |->
		($past(st_q.wst) == W_DOM2 && !$past(st_q.bus_lp) && $past(st_q.run_cnt) >= KD))
		else $error("wake flagged without a full pattern");

	// after the start-up time the receive output follows the filtered bus
	rx_mirror_a: assert property ((st_q.mode == M_STBY && st_q.wake && st_q.su_cnt >= KS) |=>
		rxd_o == $past(st_q.bus_lp))
		else $error("receive output does not mirror the bus after wake");

	// the detector stays idle in Normal mode
	norm_supp_a: assert property ((st_q.mode == M_NORM) |=> st_q.wst == W_IDLE)
		else $error("wake detector running in Normal mode");

	// an expired window drops all progress and flags nothing
	win_reset_a: assert property ((st_q.wst != W_IDLE && st_q.win_cnt >= KW) |=>
		(st_q.wst == W_IDLE && !$rose(st_q.wake)))
		else $error("wake detector survived window timeout");

	// a lasting switch-off undervoltage selects Off mode
	swoff_off_a: assert property ((st_q.sw_cnt >= KO) |=> st_q.mode == M_OFF)
		else $error("switch-off undervoltage did not select Off");

	// in Off mode the bus is released on the next edge
	off_bus_a: assert property ((st_q.mode == M_OFF) |=> (!bus_tx_o && !tx_drv_en_o))
		else $error("bus driven in Off mode");

	// a lasting main undervoltage forces Standby whatever the select says
	uv_stby_a: assert property ((st_q.uv_cnt >= KU && st_q.sw_cnt < KO) |=> st_q.mode == M_STBY)
		else $error("undervoltage did not force Standby");

	// an unmasked event raises the interrupt line on the next edge
	irq_set_a: assert property ((|(ev & st_q.mask) && !wb_cyc_i) |=> irq_o)
		else $error("interrupt not raised by unmasked event");

	// acknowledge stands for one cycle only
	ack_one_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge held for more than one cycle");

endmodule

`default_nettype wire

// ===== include/cwf_pkg.sv
// package: constants, timing counts and types of the wake and fail-safe controller
package cwf_pkg;

	// local timing clock
	localparam int unsigned T_CLK_NS       = 100;      // 10 MHz clock period

	// documented times, in ns
	localparam int unsigned T_WAKE_DOM_NS  = 500;      // least dominant phase of wake pattern
	localparam int unsigned T_WAKE_REC_NS  = 500;      // least recessive phase of wake pattern
	localparam int unsigned T_WAKE_TO_NS   = 1000000;  // longest time for the whole pattern
	localparam int unsigned T_STARTUP_NS   = 10000;    // receive path start-up after wake
	localparam int unsigned T_LPF_NS       = 300;      // low-power receiver filter time
	localparam int unsigned T_DOM_TO_NS    = 2000000;  // transmit dominant timeout
	localparam int unsigned T_UV_DET_NS    = 10000;    // standby undervoltage detect time
	localparam int unsigned T_SWOFF_NS     = 10000;    // switch-off undervoltage detect time
	localparam int unsigned T_STB_FLT_NS   = 1000;     // standby-select filter time

	// cycle counts: least times round up, longest times round down
	localparam int unsigned C_WAKE_DOM = (T_WAKE_DOM_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int unsigned C_WAKE_REC = (T_WAKE_REC_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int unsigned C_WAKE_TO  = T_WAKE_TO_NS / T_CLK_NS;
	localparam int unsigned C_STARTUP  = (T_STARTUP_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int unsigned C_LPF      = (T_LPF_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int unsigned C_DOM_TO   = T_DOM_TO_NS / T_CLK_NS;
	localparam int unsigned C_UV_DET   = (T_UV_DET_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int unsigned C_SWOFF    = (T_SWOFF_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int unsigned C_STB_FLT  = (T_STB_FLT_NS + T_CLK_NS - 1) / T_CLK_NS;

	// counter width
	localparam int unsigned CW = 16;

	// register byte offsets
	localparam logic [7:0] REG_STATUS = 8'h00;  // sticky events, write one to clear
	localparam logic [7:0] REG_MASK   = 8'h04;  // interrupt mask
	localparam logic [7:0] REG_STATE  = 8'h08;  // live state, read only
	localparam logic [7:0] REG_CTRL   = 8'h0c;  // control bits

	// reset values
	localparam logic [4:0] MASK_RST = 5'h00;
	localparam logic [1:0] CTRL_RST = 2'h1;

	// control bit positions
	localparam int unsigned CTRL_WAKE_EN = 0;  // enable bus wake detector
	localparam int unsigned CTRL_TX_OFF  = 1;  // force transmitter off

	// event bit positions
	localparam int unsigned EV_WAKE  = 0;
	localparam int unsigned EV_TXTO  = 1;
	localparam int unsigned EV_OT    = 2;
	localparam int unsigned EV_UV    = 3;
	localparam int unsigned EV_SWOFF = 4;

	// synchronised pin positions
	localparam int unsigned P_TXD  = 0;  // transmit input
	localparam int unsigned P_STB  = 1;  // standby-select input
	localparam int unsigned P_BUS  = 2;  // bus level, low is dominant
	localparam int unsigned P_TXF  = 3;  // transmit input floating
	localparam int unsigned P_STBF = 4;  // standby-select floating
	localparam int unsigned NPIN   = 5;

	// operating modes
	typedef enum logic [1:0] {
		M_OFF  = 2'b00,
		M_STBY = 2'b01,
		M_NORM = 2'b10
	} cwf_mode_t;

	// wake pattern detector states
	typedef enum logic [1:0] {
		W_IDLE = 2'b00,
		W_REC  = 2'b01,
		W_DOM2 = 2'b10
	} cwf_wake_t;

	// whole module state
	typedef struct packed {
		logic [NPIN-1:0] s1;       // synchroniser stage one
		logic [NPIN-1:0] s2;       // synchroniser stage two
		logic [NPIN-1:0] s3;       // synchroniser stage three
		logic [NPIN-1:0] pin;      // agreed pin levels
		cwf_mode_t       mode;     // operating mode
		cwf_wake_t       wst;      // wake detector state
		logic            bus_lp;   // low-power filtered bus level
		logic [CW-1:0]   lp_cnt;   // bus filter counter
		logic [CW-1:0]   run_cnt;  // length of current filtered level
		logic [CW-1:0]   win_cnt;  // wake window counter
		logic [CW-1:0]   su_cnt;   // start-up counter after wake
		logic [CW-1:0]   txd_cnt;  // transmit low counter
		logic [CW-1:0]   stb_cnt;  // standby-select filter counter
		logic [CW-1:0]   uv_cnt;   // standby undervoltage counter
		logic [CW-1:0]   sw_cnt;   // switch-off undervoltage counter
		logic            stb_f;    // filtered standby-select
		logic            ot_lock;  // drivers held off by overtemperature
		logic            wake;     // wake-up event flagged
		logic [3:0]      evp;      // previous event levels
		logic [4:0]      sts;      // sticky status
		logic [4:0]      mask;     // interrupt mask
		logic [1:0]      ctrl;     // control bits
		logic            ack;      // bus acknowledge
		logic [31:0]     dat;      // bus read data
		logic            rxd;      // receive output
		logic            drv_en;   // transmitter enabled
		logic            tx;       // driving dominant
	} cwf_state_t;

endpackage

// ===== sim/cwf_host_model.sv
// host protocol controller model driving the transmit and select pins
`timescale 1ns/1ps
`default_nettype none

module cwf_host_model (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// requests from the bench
	input  wire logic       normal_i,
	input  wire logic       tx_bit_i,
	input  wire logic [3:0] lag_i,
	// pins toward the controller
	output logic            txd_o,
	output logic            stb_sel_o
);
	logic [3:0] wait_q;  // cycles since last pin update

	// pins move only every lag_i+1 cycles, so a slow host is modelled too
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wait_q    <= 4'h0;
			txd_o     <= 1'b1;
			stb_sel_o <= 1'b1;
		end else if (wait_q < lag_i) begin
			wait_q <= wait_q + 4'h1;
		end else begin
			wait_q    <= 4'h0;
			stb_sel_o <= ~normal_i;
			// in standby both pins sit high to keep current low
			txd_o     <= normal_i ? tx_bit_i : 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench of the wake and fail-safe controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("wrong value %s exp %h got %h", nm, e, g); end end

module tb;
	import cwf_pkg::*;
	// shortened counts for simulation
	localparam int KD = 5, KR = 5, KTO = 200, KS = 10, KL = 3, KDT = 50, KUV = 8;
	// bench driven signals
	logic             clk_i, rst_i, remote, txf, stbf, nreq, tbit, vuv, suv, otsd, otrel;
	logic             cyc, stb, we;
	logic [7:0]       adr;
	logic [31:0]      wdat, rdat;
	logic [3:0]       lag;
	int               n_errors, comparisons, it, d1, r, d2;
	// design and model outputs
	wire logic        txd, stbs, rxd, btx, den, irq, ack, bus;
	wire logic [1:0]  mode;
	wire logic [31:0] dout;

	// bus is the wired-and of the remote node and our transmitter
	assign bus = remote & ~(btx & den);

	cwf_can_wake_failsafe_ctrl #(.K_WAKE_DOM(KD), .K_WAKE_REC(KR), .K_WAKE_TO(KTO), .K_STARTUP(KS),
		.K_LPF(KL), .K_DOM_TO(KDT), .K_UV_DET(KUV), .K_SWOFF(KUV), .K_STB_FLT(10)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .txd_i(txd), .txd_float_i(txf), .stb_sel_i(stbs),
		.stb_float_i(stbf), .rxd_o(rxd), .bus_rx_i(bus), .bus_tx_o(btx), .tx_drv_en_o(den),
		.vcc_uv_i(vuv), .swoff_uv_i(suv), .ot_sd_i(otsd), .ot_rel_i(otrel), .mode_o(mode),
		.irq_o(irq), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack));

	cwf_host_model host (.clk_i(clk_i), .rst_i(rst_i), .normal_i(nreq), .tx_bit_i(tbit),
		.lag_i(lag), .txd_o(txd), .stb_sel_o(stbs));

	// 10 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// expected wake flag from the three phase lengths in cycles
	function automatic logic wake_exp(input int a, input int b, input int c);
		return a >= KD + KL && b >= KR + KL && c >= KD + KL && b + c < KTO - 2 * KL;
	endfunction

	// observed level selected by index
	function automatic logic pick(input int k);
		case (k)
			0: return rxd;
			1: return den;
			2: return bus;
			3: return irq;
			4: return mode === M_STBY;
			5: return mode === M_NORM;
			default: return mode === M_OFF;
		endcase
	endfunction

	// counts, verdict and end of run
	task automatic print_verdict(input logic hung);
		if (hung) n_errors++;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// bounded wait for a level; a miss ends the run
	task automatic wait_lvl(input string nm, input int k, input logic v, input int lim);
		int i;
		for (i = 0; i < lim && pick(k) !== v; i++) @(posedge clk_i);
		comparisons++;
		if (i == lim) begin
			$display("wrong value %s exp %h got %h", nm, v, pick(k));
			print_verdict(1'b1);
		end
	endtask

	// level must stay put for n cycles
	task automatic hold(input string nm, input int k, input logic v, input int n);
		repeat (n) begin
			@(posedge clk_i);
			`CHK(nm, v, pick(k))
		end
	endtask

	// remote node holds the bus at one level for n cycles
	task automatic ph(input logic lv, input int n);
		remote <= lv;
		repeat (n) @(posedge clk_i);
	endtask

	// classic wishbone cycle, entered just after a rising edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (ack === 1'b1) break;
		end
		if (i == 20) print_verdict(1'b1);
		rdat = dout;
		{cyc, stb, we} <= 3'b000;
		@(posedge clk_i);
	endtask

	// leave standby through normal so the wake flag drops
	task automatic rearm();
		wb(1'b1, REG_STATUS, 32'h1f);
		wait_lvl("irq cleared", 3, 1'b0, 5);
		nreq <= 1'b1;
		wait_lvl("normal", 5, 1'b1, 60);
		nreq <= 1'b0;
		wait_lvl("standby", 4, 1'b1, 60);
	endtask

	initial begin
		rst_i = 1'b1;
		remote = 1'b1;
		tbit = 1'b1;
		{txf, stbf, nreq, vuv, suv, otsd, otrel, cyc, stb, we} = '0;
		adr = 8'h00;
		wdat = 32'h0;
		lag = 4'h0;
		n_errors = 0;
		comparisons = 0;
		void'($urandom(30915));
		repeat (20) @(posedge clk_i);
		`CHK("rxd in reset", 1'b1, rxd)
		rst_i <= 1'b0;
		wait_lvl("standby after reset", 4, 1'b1, 40);
		wb(1'b1, 8'h10, 32'hffffffff);
		wb(1'b0, 8'h10, 32'h0);
		`CHK("unmapped", 32'h0, rdat)
		wb(1'b0, REG_CTRL, 32'h0);
		`CHK("ctrl reset", 32'h1, rdat)
		wb(1'b1, REG_MASK, 32'h1);
		// glitches shorter than the low-power filter
		repeat (4) begin
			ph(1'b0, 2);
			ph(1'b1, 8);
		end
		hold("rxd glitch", 0, 1'b1, 5);
		wb(1'b0, REG_STATUS, 32'h0);
		`CHK("no wake on glitch", 1'b0, rdat[EV_WAKE])
		// wake patterns: first too slow, second with a short bit inside
		for (it = 0; it < 6; it++) begin
			d1 = 12 + $urandom % 10;
			r = it == 0 ? KTO + 60 : 16 + $urandom % 20;
			d2 = 12 + $urandom % 10;
			ph(1'b0, d1);
			`CHK("rxd before wake", 1'b1, rxd)
			ph(1'b1, r / 2);
			if (it == 1) ph(1'b0, 4);
			ph(1'b1, r - r / 2);
			ph(1'b0, d2);
			ph(1'b1, 30);
			wb(1'b0, REG_STATUS, 32'h0);
			`CHK("wake flag", wake_exp(d1, r, d2), rdat[EV_WAKE])
			`CHK("wake irq", wake_exp(d1, r, d2), irq)
			if (wake_exp(d1, r, d2)) begin
				ph(1'b0, 20);
				`CHK("rxd mirrors bus", 1'b0, rxd)
				`CHK("still standby", M_STBY, mode)
				ph(1'b1, 20);
				rearm();
			end else begin
				ph(1'b1, KTO + 20);
			end
		end
		// pattern broken by normal mode, then by switch-off
		for (it = 0; it < 2; it++) begin
			ph(1'b0, 15);
			ph(1'b1, 10);
			if (it == 0) nreq <= 1'b1;
			else suv <= 1'b1;
			wait_lvl("mode left", it == 0 ? 5 : 6, 1'b1, 60);
			wait_lvl("driver state", 1, it == 0, 5);
			nreq <= 1'b0;
			suv <= 1'b0;
			wait_lvl("standby again", 4, 1'b1, 60);
			ph(1'b0, 15);
			ph(1'b1, KTO + 20);
			wb(1'b0, REG_STATUS, 32'h0);
			`CHK("wake suppressed", 1'b0, rdat[EV_WAKE])
			`CHK("switch-off event", it[0], rdat[EV_SWOFF])
			wb(1'b1, REG_STATUS, 32'h1f);
		end
		nreq <= 1'b1;
		lag <= 4'($urandom % 4);
		wait_lvl("normal", 5, 1'b1, 60);
		// floating transmit pin reads recessive
		txf <= 1'b1;
		tbit <= 1'b0;
		hold("float txd", 2, 1'b1, 15);
		txf <= 1'b0;
		wait_lvl("dominant sent", 2, 1'b0, 20);
		repeat (25) @(posedge clk_i);
		tbit <= 1'b1;
		wait_lvl("recessive again", 2, 1'b1, 20);
		tbit <= 1'b0;
		wait_lvl("dominant again", 2, 1'b0, 20);
		hold("timer restarted", 2, 1'b0, 30);
		wait_lvl("bus released", 2, 1'b1, 40);
		wb(1'b0, REG_STATUS, 32'h0);
		`CHK("timeout event", 1'b1, rdat[EV_TXTO])
		`CHK("masked irq", 1'b0, irq)
		tbit <= 1'b1;
		wait_lvl("driver enabled", 1, 1'b1, 20);
		// software can force the transmitter off
		wb(1'b1, REG_CTRL, 32'h3);
		hold("forced off", 1, 1'b0, 3);
		wb(1'b1, REG_CTRL, 32'h1);
		// overtemperature shutdown and gated recovery
		tbit <= 1'b0;
		wait_lvl("dominant", 2, 1'b0, 20);
		otsd <= 1'b1;
		wait_lvl("hot driver off", 1, 1'b0, 10);
		otsd <= 1'b0;
		otrel <= 1'b1;
		hold("txd still low", 1, 1'b0, 8);
		tbit <= 1'b1;
		wait_lvl("driver back", 1, 1'b1, 20);
		// short and long select pulses
		lag <= 4'h0;
		nreq <= 1'b0;
		repeat (5) @(posedge clk_i);
		nreq <= 1'b1;
		hold("short select pulse", 5, 1'b1, 20);
		nreq <= 1'b0;
		wait_lvl("long select", 4, 1'b1, 40);
		stbf <= 1'b1;
		nreq <= 1'b1;
		hold("float select", 4, 1'b1, 30);
		stbf <= 1'b0;
		wait_lvl("normal", 5, 1'b1, 40);
		// undervoltage forces standby and locks out select
		vuv <= 1'b1;
		wait_lvl("uv standby", 4, 1'b1, 30);
		hold("select ignored", 4, 1'b1, 20);
		vuv <= 1'b0;
		wait_lvl("uv recovered", 5, 1'b1, 40);
		wb(1'b0, REG_STATE, 32'h0);
		`CHK("state mode", M_NORM, rdat[1:0])
		print_verdict(1'b0);
	end
endmodule
`default_nettype wire
